// ### common/lbip_params.svh
// Overview of operation
// - Blink on, code n<0xF: low for n+1 slots if phase bit 0, else 15-n.
// - Codes 0x0-0x6 give low intensity in the phase whose bit is 0.
// - Codes 0x8-0xE give high intensity in the phase whose bit is 0.
// - Code 0x7 gives eight slots low, eight high, in both phases.
// - Code 0xF: static low for phase bit 0, static high-impedance for bit 1.
// - Master/ninth-output register sits at address 0x0e, read and write.
// - Bits 7..4 hold master level, bits 3..0 the ninth output level.
// - Register reads back exactly the last value written.
// - Master code m from 1 to 15 scales duty to m fifteenths.
// - Master code 0 gives zero duty; all outputs off.
// - Master code 0 stops the internal PWM oscillator.
// - Master code 0 holds every output static, no switching.
// - Ninth output code k below 0xF gives duty of k+1 sixteenths in phase bit 0, 15-k in bit 1.
// - Ninth output code 0xF: static low for phase bit 0, static high-impedance for bit 1, no PWM.
// - Blink off: phase-0 bit alone picks direct or inverted mapping.
`ifndef LBIP_PARAMS_SVH
`define LBIP_PARAMS_SVH

`define LBIP_MASTER_ADDR   8'h0e
`define LBIP_MASTER_MSB    7
`define LBIP_MASTER_LSB    4
`define LBIP_NINTH_MSB     3
`define LBIP_NINTH_LSB     0
`define LBIP_REG_RESET     8'h00
`define LBIP_CODE_STATIC   4'hf
`define LBIP_MASTER_FULL   4'hf
`define LBIP_SLOT_CYCLES   8'd15
`define LBIP_SUB_LAST      4'he
`define LBIP_SLOT_LAST     4'hf

`endif

// ### common/lbip_pkg.sv
package lbip_pkg;

  typedef struct packed {
    logic [3:0] master_level;
    logic [3:0] ninth_output_level;
  } lbip_regs_type;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lbip_req_type;

  typedef enum logic [1:0] {
    LBIP_STOPPED = 2'b00,
    LBIP_RUNNING = 2'b01
  } lbip_osc_type;

endpackage

// ### test/lbip_host.sv
`timescale 1ns/100ps
`default_nettype none
module lbip_host (
  // Clock and answer
  input wire logic        clk,
  input wire logic        rvalid,
  input wire logic  [7:0] rdata,
  // Request
  output logic            wr_en = 1'b0,
  output logic            rd_en = 1'b0,
  output logic      [7:0] addr = 8'h00,
  output logic      [7:0] wdata = 8'h00
);
  // Released address and data lines show the inverse so a stale value never looks valid
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    q = 8'hxx;
    @(posedge clk);
    wr_en <= wr;
    rd_en <= !wr;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    #1;
    for (int n = 0; n < 3 && !wr && rvalid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (!wr && rvalid === 1'b1) begin
      q = rdata;
    end
  endtask
endmodule
`default_nettype wire

// ### test/lbip_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "lbip_params.svh"
module lbip_properties (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Register access
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  // Pins and status
  input wire logic [8:0] out_o,
  input wire logic [8:0] out_oe,
  input wire logic       oscillator_running
);
  logic [7:0] shadow;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shadow <= `LBIP_REG_RESET;
    end else if (wr_en && addr == `LBIP_MASTER_ADDR) begin
      shadow <= wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_read_answered: assert property (rd_en |=> rvalid) else $error("no rvalid after read");
  a_rvalid_caused: assert property (rvalid |-> $past(rd_en)) else $error("rvalid without read");
  a_read_back: assert property (rd_en && !wr_en && addr == `LBIP_MASTER_ADDR |=> rdata == shadow)
    else $error("read back differs from last write");
  a_unmapped_zero: assert property (rd_en && addr != `LBIP_MASTER_ADDR |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_open_drain: assert property (out_o == 9'h000) else $error("open-drain pin driven high");
  a_osc_start: assert property ((shadow[7:4] != 4'h0) [*3] |-> oscillator_running)
    else $error("oscillator idle with master set");
  a_osc_stop: assert property ((shadow[7:4] == 4'h0) [*3] |-> !oscillator_running)
    else $error("oscillator running with master zero");
  a_stop_releases: assert property (!oscillator_running [*3] |-> out_oe == 9'h000)
    else $error("output on while stopped");
  c_read: cover property (rvalid && rdata != 8'h00);
  c_run: cover property (oscillator_running && out_oe != 9'h000);
  c_stop: cover property ($fell(oscillator_running));
endmodule
bind lbip_top lbip_properties u_props (.clk(clk), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en),
  .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid), .out_o(out_o), .out_oe(out_oe),
  .oscillator_running(oscillator_running));
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0, reset_n = 1'b0, blink_enable = 1'b0, blink_phase = 1'b0, rvalid, osc_run;
  logic [31:0] other_levels = 32'h0;
  logic [8:0] phase0_bits = 9'h000, phase1_bits = 9'h000, out_o, out_oe;
  logic wr_en, rd_en;
  logic [7:0] addr, wdata, rdata, q;
  logic [12:0] lows [9];
  lbip_pkg::lbip_regs_type cfg;
  int n_mismatch = 0, tests_run = 0;
  lbip_host host (.clk(clk), .rvalid(rvalid), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata));
  lbip_top DUT (.clk(clk), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rvalid(rvalid), .other_levels(other_levels), .blink_enable(blink_enable),
    .blink_phase(blink_phase), .phase0_bits(phase0_bits), .phase1_bits(phase1_bits), .out_o(out_o),
    .out_oe(out_oe), .oscillator_running(osc_run));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.access(1'b0, a, 8'h00, q);
    check(q, exp);
    if ($isunknown(q)) complete_run();
  endtask
  // Low clocks in one 3840-clock period: slots times 16 clocks times master sub-steps
  function automatic int exp_low(input logic [3:0] lv, input logic pb, input logic [3:0] m);
    if (m == 4'h0) return 0;
    if (lv == 4'hf) return pb ? 0 : 3840;
    return (pb ? 15 - lv : lv + 1) * 16 * m;
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hd178aee5));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'h0e, 8'h00);
    host.access(1'b1, 8'h0e, 8'ha5, q);
    host.access(1'b1, 8'h0f, 8'h3c, q);
    rd(8'h0e, 8'ha5);
    rd(8'h0f, 8'h00);
    for (int t = 0; t < 7; t++) begin
      cfg = (t == 0) ? 8'hff : (t == 1) ? 8'h17 : (t == 2) ? 8'h0f : 8'($urandom);
      @(posedge clk);
      other_levels <= (t < 3) ? 32'hfe70fe70 : $urandom;
      phase0_bits <= (t == 0) ? 9'h0aa : 9'($urandom);
      phase1_bits <= 9'($urandom);
      blink_enable <= (t == 3) ? 1'b1 : (t > 3) ? 1'($urandom) : 1'b0;
      blink_phase <= (t == 3) ? 1'b1 : 1'($urandom);
      host.access(1'b1, 8'h0e, cfg, q);
      rd(8'h0e, cfg);
      rd(8'h0e ^ 8'($urandom_range(1, 255)), 8'h00);
      repeat (7690) @(posedge clk);
      for (int i = 0; i < 9; i++) lows[i] = 13'h0;
      repeat (3840) begin
        @(posedge clk);
        // Sample after the edge so the pins have settled
        #1;
        for (int i = 0; i < 9; i++) lows[i] = lows[i] + out_oe[i];
      end
      check(osc_run, cfg.master_level != 4'h0);
      for (int i = 0; i < 9; i++) begin
        check(lows[i], exp_low(i < 8 ? other_levels[4 * i +: 4] : cfg.ninth_output_level,
          (blink_enable && blink_phase) ? phase1_bits[i] : phase0_bits[i], cfg.master_level));
      end
      $display("test %0d done", t);
    end
    complete_run();
  end
endmodule
`default_nettype wire

// ### verilog/lbip_channel.sv
`timescale 1ns/100ps
`default_nettype none
`include "lbip_params.svh"

// One output channel: decides whether the pin is pulled low in this slot.
module lbip_channel (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Timing
  input  wire logic       period_start,
  input  wire logic [3:0] slot,
  input  wire logic       master_gate,
  input  wire logic       running,
  // Settings, latched at the period boundary
  input  wire logic [3:0] level,
  input  wire logic       phase_bit,
  // Pin
  output logic            drive_low
);

  logic [3:0] level_q;
  logic       phase_q;

  // ----------------------------------------------------------------
  // Period-aligned capture
  // ----------------------------------------------------------------
  // Latching only at the boundary keeps a running period intact
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      level_q <= 4'h0;
      phase_q <= 1'b0;
    end else if (period_start || !running) begin
      level_q <= level;
      phase_q <= phase_bit;
    end
  end

  // ----------------------------------------------------------------
  // Low-time decision
  // ----------------------------------------------------------------
  logic [4:0] low_slots;
  logic       in_low;
  always_comb begin
    // Phase 0 gives n+1 slots, phase 1 the complement 15-n
    if (phase_q) low_slots = 5'd15 - {1'b0, level_q};
    else low_slots = {1'b0, level_q} + 5'd1;
    in_low = ({1'b0, slot} < low_slots);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      drive_low <= 1'b0;
    end else if (!running) begin
      drive_low <= 1'b0;
    end else if (level_q == `LBIP_CODE_STATIC) begin
      drive_low <= !phase_q;
    end else begin
      drive_low <= in_low && master_gate;
    end
  end

endmodule
`default_nettype wire

// ### verilog/lbip_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "lbip_params.svh"

// Intensity block for nine open-drain outputs. Open-drain pins only ever
// drive low, so output enable equals drive-low and the driven value is 0.
module lbip_top (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Register access from the serial front end
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  output logic            rvalid,
  // Settings of the other outputs and blink control
  input  wire logic [31:0] other_levels,
  input  wire logic        blink_enable,
  input  wire logic        blink_phase,
  input  wire logic [8:0]  phase0_bits,
  input  wire logic [8:0]  phase1_bits,
  // Open-drain pins
  output logic [8:0]      out_o,
  output logic [8:0]      out_oe,
  // Status
  output logic            oscillator_running
);

  lbip_pkg::lbip_regs_type regs;
  lbip_pkg::lbip_req_type  req;
  lbip_pkg::lbip_osc_type  osc_state;

  assign req = '{wr_en: wr_en, rd_en: rd_en, addr: addr, wdata: wdata};

  function automatic logic hits_master(input logic [7:0] a);
    hits_master = (a == `LBIP_MASTER_ADDR);
  endfunction

  // ----------------------------------------------------------------
  // Master and ninth output register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regs <= `LBIP_REG_RESET;
    end else if (req.wr_en && hits_master(req.addr)) begin
      regs.master_level       <= req.wdata[`LBIP_MASTER_MSB:`LBIP_MASTER_LSB];
      regs.ninth_output_level <= req.wdata[`LBIP_NINTH_MSB:`LBIP_NINTH_LSB];
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd_en;
      if (req.rd_en) rdata <= hits_master(req.addr) ? regs : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator and slot timing
  // ----------------------------------------------------------------
  logic [7:0] prescale;
  logic [3:0] sub;
  logic [3:0] slot;
  logic       slot_tick;
  logic       period_start;
  logic       running;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      osc_state <= lbip_pkg::LBIP_STOPPED;
    end else begin
      case (osc_state)
        lbip_pkg::LBIP_STOPPED:
          if (regs.master_level != 4'h0) osc_state <= lbip_pkg::LBIP_RUNNING;
        lbip_pkg::LBIP_RUNNING:
          if (regs.master_level == 4'h0) osc_state <= lbip_pkg::LBIP_STOPPED;
        default: osc_state <= lbip_pkg::LBIP_STOPPED;
      endcase
    end
  end

  assign running   = (osc_state == lbip_pkg::LBIP_RUNNING);
  assign slot_tick = (prescale == `LBIP_SLOT_CYCLES);

  // Each slot is cut into 15 sub-steps so the master gate gives m/15
  always_ff @(posedge clk) begin
    if (!reset_n || !running) begin
      prescale <= 8'h00;
      sub      <= 4'h0;
      slot     <= 4'h0;
    end else if (prescale == `LBIP_SLOT_CYCLES) begin
      prescale <= 8'h00;
      if (sub == `LBIP_SUB_LAST) begin
        sub  <= 4'h0;
        slot <= slot + 4'h1;
      end else begin
        sub <= sub + 4'h1;
      end
    end else begin
      prescale <= prescale + 8'h01;
    end
  end

  assign period_start = slot_tick && (sub == `LBIP_SUB_LAST) && (slot == `LBIP_SLOT_LAST);

  // Master level latched per period as well, so duty never tears mid-period
  logic [3:0] master_q;
  always_ff @(posedge clk) begin
    if (!reset_n) master_q <= 4'h0;
    else if (period_start || !running) master_q <= regs.master_level;
  end

  logic master_gate;
  assign master_gate = ({1'b0, sub} < {1'b0, master_q});

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  logic [35:0] all_levels;
  logic [8:0]  active_bits;
  logic [8:0]  drive_low;
  assign all_levels  = {regs.ninth_output_level, other_levels};
  // Blink off: phase-0 bits alone choose the mapping
  assign active_bits = (blink_enable && blink_phase) ? phase1_bits : phase0_bits;

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi = gi + 1) begin : g_chan
      lbip_channel u_chan (
        .clk          (clk),
        .reset_n      (reset_n),
        .period_start (period_start),
        .slot         (slot),
        .master_gate  (master_gate),
        .running      (running),
        .level        (all_levels[gi*4 +: 4]),
        .phase_bit    (active_bits[gi]),
        .drive_low    (drive_low[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_o              <= 9'h000;
      out_oe             <= 9'h000;
      oscillator_running <= 1'b0;
    end else begin
      out_o              <= 9'h000;
      out_oe             <= drive_low;
      oscillator_running <= running;
    end
  end

endmodule
`default_nettype wire
